// ==== rtl/sfod_pkg.sv ====
package sfod_pkg;

	// ****************************************
	// Opcodes
	// ****************************************
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_READ4 = 8'h13;
	localparam logic [7:0] OP_FAST_READ = 8'h0B;
	localparam logic [7:0] OP_FAST_READ4 = 8'h0C;
	localparam logic [7:0] OP_DDR_FAST = 8'h0D;
	localparam logic [7:0] OP_DDR_FAST4 = 8'h0E;
	localparam logic [7:0] OP_TWO_OUT = 8'h3B;
	localparam logic [7:0] OP_TWO_OUT4 = 8'h3C;
	localparam logic [7:0] OP_FOUR_OUT = 8'h6B;
	localparam logic [7:0] OP_FOUR_OUT4 = 8'h6C;
	localparam logic [7:0] OP_TWO_IO = 8'hBB;
	localparam logic [7:0] OP_TWO_IO4 = 8'hBC;
	localparam logic [7:0] OP_DDR_TWO_IO = 8'hBD;
	localparam logic [7:0] OP_DDR_TWO_IO4 = 8'hBE;
	localparam logic [7:0] OP_FOUR_IO = 8'hEB;
	localparam logic [7:0] OP_FOUR_IO4 = 8'hEC;
	localparam logic [7:0] OP_DDR_FOUR_IO = 8'hED;
	localparam logic [7:0] OP_DDR_FOUR_IO4 = 8'hEE;
	localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
	localparam logic [7:0] OP_PAGE_WRITE4 = 8'h12;
	localparam logic [7:0] OP_FOUR_PAGE_A = 8'h32;
	localparam logic [7:0] OP_FOUR_PAGE_B = 8'h38;
	localparam logic [7:0] OP_FOUR_PAGE4 = 8'h34;
	localparam logic [7:0] OP_SECTOR_WIPE = 8'hD8;
	localparam logic [7:0] OP_SECTOR_WIPE4 = 8'hDC;
	localparam logic [7:0] OP_FULL_WIPE = 8'h60;
	localparam logic [7:0] OP_FULL_WIPE_ALT = 8'hC7;
	localparam logic [7:0] OP_IDENTITY = 8'h9F;
	localparam logic [7:0] OP_DISC_PARAM = 8'h5A;
	localparam logic [7:0] OP_BANK_ACCESS = 8'hB9;
	localparam logic [7:0] OP_HIGH_PERF = 8'hA3;
	localparam logic [7:0] OP_CALIB_READ = 8'h41;
	localparam logic [7:0] OP_CALIB_NV_WRITE = 8'h43;
	localparam logic [7:0] OP_CALIB_VOL_WRITE = 8'h4A;
	localparam logic [7:0] OP_MODE_EXIT = 8'hFF;

	// ****************************************
	// Clock limits in MHz
	// ****************************************
	localparam logic [7:0] MHZ_NONE = 8'h00;
	localparam logic [7:0] MHZ_50 = 8'h32;
	localparam logic [7:0] MHZ_80 = 8'h50;
	localparam logic [7:0] MHZ_104 = 8'h68;
	localparam logic [7:0] MHZ_133 = 8'h85;

	localparam logic [3:0] OPCODE_BITS = 4'h8;
	localparam logic [3:0] MODE_EXIT_BITS = 4'h8;
	// Sector erased by one sector wipe, in kB
	localparam int SECTOR_KB = 256;

	typedef enum logic [4:0] {
		SFOD_CMD_NONE,
		SFOD_CMD_READ,
		SFOD_CMD_FAST_READ,
		SFOD_CMD_DDR_FAST_READ,
		SFOD_CMD_TWO_OUT_READ,
		SFOD_CMD_FOUR_OUT_READ,
		SFOD_CMD_TWO_IO_READ,
		SFOD_CMD_DDR_TWO_IO_READ,
		SFOD_CMD_FOUR_IO_READ,
		SFOD_CMD_DDR_FOUR_IO_READ,
		SFOD_CMD_PAGE_WRITE,
		SFOD_CMD_FOUR_PAGE_WRITE,
		SFOD_CMD_SECTOR_WIPE,
		SFOD_CMD_FULL_WIPE,
		SFOD_CMD_IDENTITY,
		SFOD_CMD_DISC_PARAM,
		SFOD_CMD_BANK_ACCESS,
		SFOD_CMD_CALIB_READ,
		SFOD_CMD_CALIB_NV_WRITE,
		SFOD_CMD_CALIB_VOL_WRITE,
		SFOD_CMD_MODE_EXIT,
		SFOD_CMD_RESERVED
	} sfod_cmd_e;

	typedef struct packed {
		sfod_cmd_e cmd;
		logic addr4_forced;
		logic [7:0] max_mhz;
		logic [7:0] opcode;
	} sfod_decode_s;

	typedef struct packed {
		logic nv_reg_write;
		logic otp_write;
	} sfod_nv_req_s;

	typedef struct packed {
		logic nv_array_cycle;
		logic otp_program;
	} sfod_nv_op_s;

endpackage

// ==== rtl/sfod_nv_steer.sv ====
`timescale 1ns/1ps

// ****************************************
// Nonvolatile write steering
// ****************************************
module sfod_nv_steer (
	input wire logic clock,
	input wire logic rst,
	input wire sfod_pkg::sfod_nv_req_s req,
	output sfod_pkg::sfod_nv_op_s op
);
	typedef struct packed {
		sfod_pkg::sfod_nv_op_s op;
	} sfod_steer_state_s;

	sfod_steer_state_s state_reg;
	sfod_steer_state_s state_next;

	always_comb begin
		state_next = state_reg;
		// Any register write cycles the whole nonvolatile array, never one register
		state_next.op.nv_array_cycle = req.nv_reg_write;
		// One-time bits live apart and never see an array cycle
		state_next.op.otp_program = req.otp_write && !req.nv_reg_write;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign op = state_reg.op;
endmodule

// ==== rtl/sfod_decoder.sv ====
`timescale 1ns/1ps


module sfod_decoder (
	input wire logic clock,
	input wire logic rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic continuous_mode,
	input wire logic nv_reg_write,
	input wire logic otp_write,
	output sfod_pkg::sfod_decode_s decode,
	output logic decode_valid,
	output logic busy,
	output logic ignoring,
	output logic mode_exit,
	output sfod_pkg::sfod_nv_op_s nv_op
);

	// ****************************************
	// Opcode classification
	// ****************************************
	function automatic sfod_pkg::sfod_decode_s classify(input logic [7:0] op);
		sfod_pkg::sfod_decode_s d;
		d.opcode = op;
		d.addr4_forced = 1'b0;
		d.max_mhz = sfod_pkg::MHZ_133;
		d.cmd = sfod_pkg::SFOD_CMD_RESERVED;
		case (op)
			sfod_pkg::OP_READ: begin
				d.cmd = sfod_pkg::SFOD_CMD_READ;
				d.max_mhz = sfod_pkg::MHZ_50;
			end
			sfod_pkg::OP_READ4: begin
				d.cmd = sfod_pkg::SFOD_CMD_READ;
				d.addr4_forced = 1'b1;
				d.max_mhz = sfod_pkg::MHZ_50;
			end
			sfod_pkg::OP_FAST_READ: begin
				d.cmd = sfod_pkg::SFOD_CMD_FAST_READ;
			end
			sfod_pkg::OP_FAST_READ4: begin
				d.cmd = sfod_pkg::SFOD_CMD_FAST_READ;
				d.addr4_forced = 1'b1;
			end
			sfod_pkg::OP_DDR_FAST: begin
				d.cmd = sfod_pkg::SFOD_CMD_DDR_FAST_READ;
				d.max_mhz = sfod_pkg::MHZ_80;
			end
			sfod_pkg::OP_DDR_FAST4: begin
				d.cmd = sfod_pkg::SFOD_CMD_DDR_FAST_READ;
				d.addr4_forced = 1'b1;
				d.max_mhz = sfod_pkg::MHZ_80;
			end
			sfod_pkg::OP_TWO_OUT: begin
				d.cmd = sfod_pkg::SFOD_CMD_TWO_OUT_READ;
				d.max_mhz = sfod_pkg::MHZ_104;
			end
			sfod_pkg::OP_TWO_OUT4: begin
				d.cmd = sfod_pkg::SFOD_CMD_TWO_OUT_READ;
				d.addr4_forced = 1'b1;
				d.max_mhz = sfod_pkg::MHZ_104;
			end
			sfod_pkg::OP_FOUR_OUT: begin
				d.cmd = sfod_pkg::SFOD_CMD_FOUR_OUT_READ;
				d.max_mhz = sfod_pkg::MHZ_104;
			end
			sfod_pkg::OP_FOUR_OUT4: begin
				d.cmd = sfod_pkg::SFOD_CMD_FOUR_OUT_READ;
				d.addr4_forced = 1'b1;
				d.max_mhz = sfod_pkg::MHZ_104;
			end
			sfod_pkg::OP_TWO_IO: begin
				d.cmd = sfod_pkg::SFOD_CMD_TWO_IO_READ;
				d.max_mhz = sfod_pkg::MHZ_104;
			end
			sfod_pkg::OP_TWO_IO4: begin
				d.cmd = sfod_pkg::SFOD_CMD_TWO_IO_READ;
				d.addr4_forced = 1'b1;
				d.max_mhz = sfod_pkg::MHZ_104;
			end
			sfod_pkg::OP_DDR_TWO_IO: begin
				d.cmd = sfod_pkg::SFOD_CMD_DDR_TWO_IO_READ;
				d.max_mhz = sfod_pkg::MHZ_80;
			end
			sfod_pkg::OP_DDR_TWO_IO4: begin
				d.cmd = sfod_pkg::SFOD_CMD_DDR_TWO_IO_READ;
				d.addr4_forced = 1'b1;
				d.max_mhz = sfod_pkg::MHZ_80;
			end
			sfod_pkg::OP_FOUR_IO: begin
				d.cmd = sfod_pkg::SFOD_CMD_FOUR_IO_READ;
				d.max_mhz = sfod_pkg::MHZ_104;
			end
			sfod_pkg::OP_FOUR_IO4: begin
				d.cmd = sfod_pkg::SFOD_CMD_FOUR_IO_READ;
				d.addr4_forced = 1'b1;
				d.max_mhz = sfod_pkg::MHZ_104;
			end
			sfod_pkg::OP_DDR_FOUR_IO: begin
				d.cmd = sfod_pkg::SFOD_CMD_DDR_FOUR_IO_READ;
				d.max_mhz = sfod_pkg::MHZ_80;
			end
			sfod_pkg::OP_DDR_FOUR_IO4: begin
				d.cmd = sfod_pkg::SFOD_CMD_DDR_FOUR_IO_READ;
				d.addr4_forced = 1'b1;
				d.max_mhz = sfod_pkg::MHZ_80;
			end
			sfod_pkg::OP_PAGE_WRITE: begin
				d.cmd = sfod_pkg::SFOD_CMD_PAGE_WRITE;
			end
			sfod_pkg::OP_PAGE_WRITE4: begin
				d.cmd = sfod_pkg::SFOD_CMD_PAGE_WRITE;
				d.addr4_forced = 1'b1;
			end
			sfod_pkg::OP_FOUR_PAGE_A, sfod_pkg::OP_FOUR_PAGE_B: begin
				d.cmd = sfod_pkg::SFOD_CMD_FOUR_PAGE_WRITE;
				d.max_mhz = sfod_pkg::MHZ_80;
			end
			sfod_pkg::OP_FOUR_PAGE4: begin
				d.cmd = sfod_pkg::SFOD_CMD_FOUR_PAGE_WRITE;
				d.addr4_forced = 1'b1;
				d.max_mhz = sfod_pkg::MHZ_80;
			end
			sfod_pkg::OP_SECTOR_WIPE: begin
				d.cmd = sfod_pkg::SFOD_CMD_SECTOR_WIPE;
			end
			sfod_pkg::OP_SECTOR_WIPE4: begin
				d.cmd = sfod_pkg::SFOD_CMD_SECTOR_WIPE;
				d.addr4_forced = 1'b1;
			end
			sfod_pkg::OP_FULL_WIPE, sfod_pkg::OP_FULL_WIPE_ALT: begin
				d.cmd = sfod_pkg::SFOD_CMD_FULL_WIPE;
			end
			sfod_pkg::OP_IDENTITY: begin
				d.cmd = sfod_pkg::SFOD_CMD_IDENTITY;
			end
			sfod_pkg::OP_DISC_PARAM: begin
				d.cmd = sfod_pkg::SFOD_CMD_DISC_PARAM;
			end
			sfod_pkg::OP_BANK_ACCESS: begin
				// Legacy power-down meaning is gone on purpose
				d.cmd = sfod_pkg::SFOD_CMD_BANK_ACCESS;
			end
			sfod_pkg::OP_HIGH_PERF: begin
				d.cmd = sfod_pkg::SFOD_CMD_RESERVED;
			end
			sfod_pkg::OP_CALIB_READ: begin
				d.cmd = sfod_pkg::SFOD_CMD_CALIB_READ;
			end
			sfod_pkg::OP_CALIB_NV_WRITE: begin
				d.cmd = sfod_pkg::SFOD_CMD_CALIB_NV_WRITE;
			end
			sfod_pkg::OP_CALIB_VOL_WRITE: begin
				d.cmd = sfod_pkg::SFOD_CMD_CALIB_VOL_WRITE;
			end
			sfod_pkg::OP_MODE_EXIT: begin
				d.cmd = sfod_pkg::SFOD_CMD_MODE_EXIT;
			end
			default: begin
				d.cmd = sfod_pkg::SFOD_CMD_RESERVED;
				d.max_mhz = sfod_pkg::MHZ_NONE;
			end
		endcase
		if (d.cmd == sfod_pkg::SFOD_CMD_RESERVED) begin
			d.max_mhz = sfod_pkg::MHZ_NONE;
		end
		return d;
	endfunction

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [1:0] {
		SFOD_ST_IDLE,
		SFOD_ST_OPCODE,
		SFOD_ST_HOLD,
		SFOD_ST_IGNORE
	} sfod_phase_e;

	typedef struct packed {
		logic [1:0] sck_sync;
		logic [1:0] cs_sync;
		logic [1:0] si_sync;
		logic sck_last;
		sfod_phase_e phase;
		logic [7:0] shift;
		logic [3:0] bit_count;
		logic [3:0] ones_count;
		sfod_pkg::sfod_decode_s decode;
		logic decode_valid;
		logic mode_exit;
	} sfod_state_s;

	sfod_state_s state_reg;
	sfod_state_s state_next;

	logic sck_rise;
	logic cs_active;
	logic si_level;

	// Link pins only read after their second flop
	assign sck_rise = state_reg.sck_sync[1] && !state_reg.sck_last;
	assign cs_active = !state_reg.cs_sync[1];
	assign si_level = state_reg.si_sync[1];

	always_comb begin
		state_next = state_reg;
		state_next.sck_sync = {state_reg.sck_sync[0], sck};
		state_next.cs_sync = {state_reg.cs_sync[0], cs_n};
		state_next.si_sync = {state_reg.si_sync[0], si};
		state_next.sck_last = state_reg.sck_sync[1];
		state_next.decode_valid = 1'b0;
		state_next.mode_exit = 1'b0;

		if (!cs_active) begin
			// Select high ends every frame, including an ignored one
			state_next.phase = SFOD_ST_IDLE;
			state_next.bit_count = 4'h0;
			state_next.ones_count = 4'h0;
		end else begin
			case (state_reg.phase)
				SFOD_ST_IDLE, SFOD_ST_OPCODE: begin
					state_next.phase = SFOD_ST_OPCODE;
					if (sck_rise) begin
						state_next.shift = {state_reg.shift[6:0], si_level};
						state_next.bit_count = state_reg.bit_count + 4'h1;
						// Only the primary line counts toward the exit sequence
						if (si_level) begin
							state_next.ones_count = state_reg.ones_count + 4'h1;
						end
						if (state_reg.bit_count == sfod_pkg::OPCODE_BITS - 4'h1) begin
							state_next.decode = classify({state_reg.shift[6:0], si_level});
							if (continuous_mode) begin
								// In continuous mode only eight ones leave the mode
								if (si_level &&
									state_reg.ones_count == sfod_pkg::MODE_EXIT_BITS - 4'h1) begin
									state_next.mode_exit = 1'b1;
								end
								state_next.phase = SFOD_ST_IGNORE;
							end else if (state_next.decode.cmd == sfod_pkg::SFOD_CMD_RESERVED) begin
								state_next.phase = SFOD_ST_IGNORE;
							end else begin
								state_next.decode_valid = 1'b1;
								state_next.phase = SFOD_ST_HOLD;
							end
						end
					end
				end
				SFOD_ST_HOLD: begin
					state_next.phase = SFOD_ST_HOLD;
				end
				SFOD_ST_IGNORE: begin
					state_next.phase = SFOD_ST_IGNORE;
				end
				default: begin
					state_next.phase = SFOD_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= '{
				sck_sync: 2'h0,
				cs_sync: 2'h3,
				si_sync: 2'h0,
				sck_last: 1'b0,
				phase: SFOD_ST_IDLE,
				shift: 8'h00,
				bit_count: 4'h0,
				ones_count: 4'h0,
				decode: '0,
				decode_valid: 1'b0,
				mode_exit: 1'b0
			};
		end else begin
			state_reg <= state_next;
		end
	end

	assign decode = state_reg.decode;
	assign decode_valid = state_reg.decode_valid;
	assign busy = state_reg.phase == SFOD_ST_HOLD;
	assign ignoring = state_reg.phase == SFOD_ST_IGNORE;
	assign mode_exit = state_reg.mode_exit;

	// ****************************************
	// Nonvolatile array steering
	// ****************************************
	sfod_pkg::sfod_nv_req_s nv_req;
	assign nv_req.nv_reg_write = nv_reg_write;
	assign nv_req.otp_write = otp_write;

	sfod_nv_steer u_nv_steer (
		.clock(clock),
		.rst(rst),
		.req(nv_req),
		.op(nv_op)
	);
endmodule

// ==== verif/sfod_decoder_props.sv ====
`timescale 1ns/1ps

module sfod_decoder_props (
	input wire logic clock,
	input wire logic rst,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic continuous_mode,
	input wire logic nv_reg_write,
	input wire logic otp_write,
	input wire sfod_pkg::sfod_decode_s decode,
	input wire logic decode_valid,
	input wire logic busy,
	input wire logic ignoring,
	input wire logic mode_exit,
	input wire sfod_pkg::sfod_nv_op_s nv_op
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	chk_read_rate: assert property (decode_valid && decode.cmd == sfod_pkg::SFOD_CMD_READ |-> decode.max_mhz == 8'h32)
		else $error("read limit wrong");
	chk_fast_rate: assert property (decode_valid && decode.cmd == sfod_pkg::SFOD_CMD_FAST_READ |-> decode.max_mhz == 8'h85)
		else $error("fast read limit wrong");
	chk_ddr_rate: assert property (decode_valid && decode.cmd inside {sfod_pkg::SFOD_CMD_DDR_FAST_READ,
		sfod_pkg::SFOD_CMD_DDR_TWO_IO_READ, sfod_pkg::SFOD_CMD_DDR_FOUR_IO_READ} |-> decode.max_mhz == 8'h50)
		else $error("double rate limit wrong");
	chk_multi_rate: assert property (decode_valid && decode.cmd inside {sfod_pkg::SFOD_CMD_TWO_OUT_READ,
		sfod_pkg::SFOD_CMD_FOUR_OUT_READ, sfod_pkg::SFOD_CMD_TWO_IO_READ, sfod_pkg::SFOD_CMD_FOUR_IO_READ}
		|-> decode.max_mhz == 8'h68)
		else $error("multi line limit wrong");
	chk_page_rate: assert property (decode_valid && decode.cmd == sfod_pkg::SFOD_CMD_FOUR_PAGE_WRITE
		|-> decode.max_mhz == 8'h50 && decode.opcode inside {8'h32, 8'h38, 8'h34})
		else $error("page write decode wrong");
	chk_reserved_quiet: assert property (decode_valid |-> decode.cmd != sfod_pkg::SFOD_CMD_RESERVED)
		else $error("reserved code reported valid");
	chk_ignore_hold: assert property ((ignoring && !cs_n) [*4] |=> ignoring)
		else $error("ignore state left while selected");
	chk_nv_cycle: assert property (!$past(rst) |-> nv_op.nv_array_cycle == $past(nv_reg_write))
		else $error("array cycle not following write");
	chk_otp_apart: assert property (!$past(rst) |-> nv_op.otp_program == ($past(otp_write) && !$past(nv_reg_write)))
		else $error("otp program wrong");
	chk_exit_mode: assert property (mode_exit |-> continuous_mode && !decode_valid)
		else $error("mode exit outside continuous mode");
	chk_busy_start: assert property ($rose(busy) |-> decode_valid)
		else $error("busy without a valid decode");

	cov_valid: cover property (decode_valid);
	cov_exit: cover property (mode_exit);
	cov_ignore: cover property ($rose(ignoring));
endmodule

bind sfod_decoder sfod_decoder_props u_sfod_decoder_props (.clock(clock), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
	.continuous_mode(continuous_mode), .nv_reg_write(nv_reg_write), .otp_write(otp_write), .decode(decode),
	.decode_valid(decode_valid), .busy(busy), .ignoring(ignoring), .mode_exit(mode_exit), .nv_op(nv_op));

// ==== verif/sfod_host_model.sv ====
`timescale 1ns/1ps

module sfod_host_model (
	input wire logic clock,
	output logic sck,
	output logic cs_n,
	output logic si
);
	// Half of a 160 ns link period: far below every command's clock limit
	localparam int HALF = 20;

	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// One frame, MSB first, n leading bits of the value; eight leading ones give the mode exit in continuous mode
	task automatic send(input logic [15:0] bits, input int n);
		int i;
		@(negedge clock);
		cs_n = 1'b0;
		for (i = 15; i > 15 - n; i--) begin
			repeat (HALF) @(negedge clock);
			sck = 1'b0;
			si = bits[i];
			repeat (HALF) @(negedge clock);
			sck = 1'b1;
		end
		repeat (HALF) @(negedge clock);
		sck = 1'b0;
		repeat (HALF) @(negedge clock);
		cs_n = 1'b1;
		// Released line must not keep showing the last bit
		si = ~si;
		repeat (8) @(negedge clock);
	endtask
endmodule

// ==== verif/sfod_decoder_bench.sv ====
`timescale 1ns/1ps

module sfod_decoder_bench;
	typedef struct packed {
		logic [1:0] kind;
		sfod_pkg::sfod_decode_s d;
	} sfod_exp_s;
	logic clock;
	logic rst;
	logic sck;
	logic cs_n;
	logic si;
	logic continuous_mode;
	logic nv_reg_write;
	logic otp_write;
	sfod_pkg::sfod_decode_s decode;
	logic decode_valid;
	logic busy;
	logic ignoring;
	logic mode_exit;
	sfod_pkg::sfod_nv_op_s nv_op;
	int err_count;
	int samples_checked;
	int i;
	sfod_exp_s exp_q[$];
	sfod_exp_s e;
	logic nv_prev;
	logic otp_prev;
	logic ign_prev;
	logic [7:0] op;
	sfod_pkg::sfod_decode_s d_probe;

	sfod_decoder u_sfod_decoder (.clock(clock), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
		.continuous_mode(continuous_mode), .nv_reg_write(nv_reg_write), .otp_write(otp_write), .decode(decode),
		.decode_valid(decode_valid), .busy(busy), .ignoring(ignoring), .mode_exit(mode_exit), .nv_op(nv_op));
	sfod_host_model u_sfod_host_model (.clock(clock), .sck(sck), .cs_n(cs_n), .si(si));

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// ****
	// Expected classification
	// ****
	function automatic sfod_pkg::sfod_decode_s exp_of(input logic [7:0] o);
		sfod_pkg::sfod_decode_s r;
		logic [4:0] c;
		logic [7:0] m;
		case (o)
			8'h03, 8'h13: {c, m} = {sfod_pkg::SFOD_CMD_READ, 8'h32};
			8'h0B, 8'h0C: {c, m} = {sfod_pkg::SFOD_CMD_FAST_READ, 8'h85};
			8'h0D, 8'h0E: {c, m} = {sfod_pkg::SFOD_CMD_DDR_FAST_READ, 8'h50};
			8'h3B, 8'h3C: {c, m} = {sfod_pkg::SFOD_CMD_TWO_OUT_READ, 8'h68};
			8'h6B, 8'h6C: {c, m} = {sfod_pkg::SFOD_CMD_FOUR_OUT_READ, 8'h68};
			8'hBB, 8'hBC: {c, m} = {sfod_pkg::SFOD_CMD_TWO_IO_READ, 8'h68};
			8'hBD, 8'hBE: {c, m} = {sfod_pkg::SFOD_CMD_DDR_TWO_IO_READ, 8'h50};
			8'hEB, 8'hEC: {c, m} = {sfod_pkg::SFOD_CMD_FOUR_IO_READ, 8'h68};
			8'hED, 8'hEE: {c, m} = {sfod_pkg::SFOD_CMD_DDR_FOUR_IO_READ, 8'h50};
			8'h02, 8'h12: {c, m} = {sfod_pkg::SFOD_CMD_PAGE_WRITE, 8'h85};
			8'h32, 8'h38, 8'h34: {c, m} = {sfod_pkg::SFOD_CMD_FOUR_PAGE_WRITE, 8'h50};
			8'hD8, 8'hDC: {c, m} = {sfod_pkg::SFOD_CMD_SECTOR_WIPE, 8'h85};
			8'h60, 8'hC7: {c, m} = {sfod_pkg::SFOD_CMD_FULL_WIPE, 8'h85};
			8'h9F: {c, m} = {sfod_pkg::SFOD_CMD_IDENTITY, 8'h85};
			8'h5A: {c, m} = {sfod_pkg::SFOD_CMD_DISC_PARAM, 8'h85};
			8'hB9: {c, m} = {sfod_pkg::SFOD_CMD_BANK_ACCESS, 8'h85};
			8'h41: {c, m} = {sfod_pkg::SFOD_CMD_CALIB_READ, 8'h85};
			8'h43: {c, m} = {sfod_pkg::SFOD_CMD_CALIB_NV_WRITE, 8'h85};
			8'h4A: {c, m} = {sfod_pkg::SFOD_CMD_CALIB_VOL_WRITE, 8'h85};
			8'hFF: {c, m} = {sfod_pkg::SFOD_CMD_MODE_EXIT, 8'h85};
			default: {c, m} = {sfod_pkg::SFOD_CMD_RESERVED, 8'h00};
		endcase
		r.cmd = sfod_pkg::sfod_cmd_e'(c);
		r.max_mhz = m;
		r.opcode = o;
		r.addr4_forced = o inside {8'h13, 8'h0C, 8'h0E, 8'h3C, 8'h6C, 8'hBC, 8'hBE, 8'hEC, 8'hEE, 8'h12, 8'h34, 8'hDC};
		return r;
	endfunction

	task automatic cmp_bit(input logic exp, input logic got, input string msg);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask

	task automatic cmp_decode(input sfod_pkg::sfod_decode_s exp, input sfod_pkg::sfod_decode_s got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t decode %h expected %h", $time, got, exp);
		end
	endtask

	// Kind 0 valid decode, 1 ignored code, 2 mode exit; random trailing bits must not matter
	task automatic frame(input logic [7:0] o, input logic [1:0] k);
		exp_q.push_back({k, exp_of(o)});
		u_sfod_host_model.send({o, 8'($urandom)}, (k == 2'h2) ? 8 : 8 + 8 * ($urandom % 2));
		// Select has been high for several clocks here, so both holding states must be gone
		cmp_bit(1'b0, busy || ignoring, "frame not released");
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ****
	// Result monitor
	// ****
	always @(posedge clock) begin
		if (!rst && (decode_valid === 1'b1 || mode_exit === 1'b1
			|| (continuous_mode === 1'b0 && ignoring === 1'b1 && ign_prev !== 1'b1))) begin
			if (exp_q.size() == 0) begin
				cmp_bit(1'b0, 1'b1, "result without request");
			end else begin
				e = exp_q.pop_front();
				cmp_bit(e.kind == 2'h0, decode_valid, "valid pulse");
				cmp_bit(e.kind == 2'h0, busy, "busy level");
				cmp_bit(e.kind == 2'h2, mode_exit, "mode exit pulse");
				if (e.kind != 2'h2) cmp_decode(e.d, decode);
			end
		end
		if (!rst) begin
			cmp_bit(nv_prev, nv_op.nv_array_cycle, "array cycle");
			cmp_bit(otp_prev && !nv_prev, nv_op.otp_program, "otp program");
		end
		ign_prev <= ignoring;
		nv_prev <= nv_reg_write;
		otp_prev <= otp_write;
	end

	initial begin
		nv_reg_write = 1'b0;
		otp_write = 1'b0;
		forever begin
			@(negedge clock);
			if (!rst) begin
				nv_reg_write = 1'($urandom);
				otp_write = 1'($urandom);
			end
		end
	end

	initial begin
		repeat (100000) @(posedge clock);
		cmp_bit(1'b0, 1'b1, "run limit reached");
		tally_and_finish();
	end

	initial begin
		rst = 1'b1;
		continuous_mode = 1'b0;
		err_count = 0;
		samples_checked = 0;
		nv_prev = 1'b0;
		otp_prev = 1'b0;
		ign_prev = 1'b0;
		void'($urandom(15513));
		repeat (6) @(negedge clock);
		rst = 1'b0;
		repeat (4) @(negedge clock);
		for (i = 0; i < 256; i++) begin
			d_probe = exp_of(i[7:0]);
			if (d_probe.cmd != sfod_pkg::SFOD_CMD_RESERVED) begin
				frame(i[7:0], 2'h0);
			end
		end
		$display("test defined codes done");
		frame(8'hA3, 2'h1);
		// A cut frame must leave no half opcode behind for the next one
		u_sfod_host_model.send(16'h0B00, 4);
		frame(8'h0B, 2'h0);
		for (i = 0; i < 4; i++) begin
			do begin
				op = 8'($urandom);
				d_probe = exp_of(op);
			end while (d_probe.cmd != sfod_pkg::SFOD_CMD_RESERVED);
			frame(op, 2'h1);
		end
		$display("test reserved codes done");
		continuous_mode = 1'b1;
		u_sfod_host_model.send(16'h03FF, 16);
		u_sfod_host_model.send(16'hFE00, 8);
		frame(8'hFF, 2'h2);
		continuous_mode = 1'b0;
		frame(8'hEC, 2'h0);
		$display("test continuous mode done");
		for (i = 0; i < 200 && exp_q.size() != 0; i++) @(posedge clock);
		cmp_bit(1'b1, exp_q.size() == 0, "result missing");
		tally_and_finish();
	end
endmodule
